// *** dv/rptt_pin_model.sv ***
// Purpose: external controller driving the rate select pin
// Assumes: pin is asynchronous to clk_sys
// Notes:   each change lands at a random offset inside a clock period
`timescale 1ns/1ps

module rptt_pin_model (
  output logic pin
);
  initial pin = 1'b0;

  // ----------------------------------------
  // one pin change, then held 8 cycles
  // ----------------------------------------
  task automatic drive(input logic v);
    #($urandom_range(17, 1));
    pin = v;
    #160;
  endtask
endmodule

// *** dv/tb.sv ***
// Purpose: self-checking bench of the rate pin transition tracker
// Assumes: inputs change 2 ns after the rising edge
// Notes:   enables stepped by the loop index, random other bits and addresses from a fixed seed
`timescale 1ns/1ps
`include "rptt_cfg.svh"

module tb;
  logic       clk_sys;
  logic       rst_b;
  logic       rate_pin;
  logic       alert_mode;
  logic       full_snap_cmd;
  logic       full_snap_bcast_cmd;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       snap_clear;
  logic       snap_keep;
  logic       snap_apply_pending;
  int         bad_count = 0;
  int         checks_done = 0;
  int         n_clear = 0;
  int         n_keep = 0;
  int         n_apply = 0;
  int         seed;
  logic [4:0] ctrl_m;
  logic       rise_m;
  logic       fall_m;

  rptt_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .rate_pin(rate_pin),
    .alert_mode(alert_mode), .full_snap_cmd(full_snap_cmd),
    .full_snap_bcast_cmd(full_snap_bcast_cmd), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .snap_clear(snap_clear),
    .snap_keep(snap_keep), .snap_apply_pending(snap_apply_pending));
  rptt_pin_model pin_ctl (.pin(rate_pin));

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    n_clear <= n_clear + int'(snap_clear === 1'b1);
    n_keep  <= n_keep + int'(snap_keep === 1'b1);
    n_apply <= n_apply + int'(snap_apply_pending !== 1'b0 && rst_b === 1'b1);
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_reg();
    return alert_mode ? 8'h00 : {1'b0, rise_m, fall_m, ctrl_m};
  endfunction

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    @(posedge clk_sys);
    #2;
    d = reg_rdata;
  endtask

  task automatic chk_reg();
    logic [7:0] d;
    rd(`RPTT_REG_ADDR, d);
    chk(d, exp_reg());
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #2;
    reg_wr = 1'b0;
    if (a == `RPTT_REG_ADDR) ctrl_m = v[4:0];
  endtask

  task automatic pulse_cmd(input logic bc);
    if (bc) full_snap_bcast_cmd = 1'b1;
    else full_snap_cmd = 1'b1;
    @(posedge clk_sys);
    #2;
    full_snap_cmd = 1'b0;
    full_snap_bcast_cmd = 1'b0;
    rise_m = 1'b0;
    fall_m = 1'b0;
  endtask

  task automatic pin_to(input logic v);
    int c0;
    int k0;
    logic go;
    c0 = n_clear;
    k0 = n_keep;
    go = v & ~alert_mode;
    pin_ctl.drive(v);
    @(posedge clk_sys);
    #2;
    if (!alert_mode && v) rise_m = 1'b1;
    if (!alert_mode && !v) fall_m = 1'b1;
    chk(8'(n_clear - c0), {7'h00, go & ctrl_m[4]});
    chk(8'(n_keep - k0), {7'h00, go & ctrl_m[3] & ~ctrl_m[4]});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] a;
    seed = $urandom(74077);
    rst_b = 1'b0;
    alert_mode = 1'b0;
    full_snap_cmd = 1'b0;
    full_snap_bcast_cmd = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    ctrl_m = `RPTT_CTRL_RESET;
    rise_m = 1'b0;
    fall_m = 1'b0;
    repeat (8) @(posedge clk_sys);
    #2;
    rst_b = 1'b1;
    chk_reg();
    a = 8'($urandom_range(255, 33));
    wr(a, 8'hff);
    rd(a, d);
    chk(d, 8'h00);
    chk_reg();
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(`RPTT_REG_ADDR, {3'($urandom), i[1:0], 3'($urandom)});
      pin_to(1'b1);
      chk_reg();
      pin_to(1'b0);
      chk_reg();
      if (i[2]) begin
        pulse_cmd(i[0]);
        chk_reg();
      end
    end
    $display("test edges done");
    alert_mode = 1'b1;
    pulse_cmd(1'b0);
    chk_reg();
    pin_to(1'b1);
    pin_to(1'b0);
    alert_mode = 1'b0;
    chk_reg();
    $display("test alert done");
    chk({7'h00, n_apply != 0}, 8'h00);
    results();
  end

  initial begin
    #50000;
    bad_count++;
    results();
  end
endmodule

// *** src/rptt_cfg.svh ***
// Purpose: constants of the rate pin transition tracker
// Assumes: included by bare name
// Notes:   definitions only
`ifndef RPTT_CFG_SVH
`define RPTT_CFG_SVH

// ----------------------------------------
// register location and layout
// ----------------------------------------
`define RPTT_REG_ADDR      8'h20
`define RPTT_BIT_RISE_SEEN 6
`define RPTT_BIT_FALL_SEEN 5
`define RPTT_BIT_EN_CLEAR  4
`define RPTT_BIT_EN_KEEP   3
`define RPTT_CTRL_MSB      4
`define RPTT_CTRL_RESET    5'h15

// ----------------------------------------
// pin synchroniser depth
// ----------------------------------------
`define RPTT_SYNC_STAGES   2

`endif

// *** src/rptt_edge_if.sv ***
// Purpose: carries the synchronised pin level and its edges
// Assumes: single clock domain
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/1ps

interface rptt_edge_if;
  logic level;
  logic rise;
  logic fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// *** src/rptt_edge_sync.sv ***
// Purpose: synchronises the rate pin and detects its edges
// Assumes: pin is asynchronous to clk_sys
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`include "rptt_cfg.svh"

module rptt_edge_sync #(
  parameter int STAGES = `RPTT_SYNC_STAGES
) (
  input  wire logic   clk_sys,
  input  wire logic   rst_b,
  input  wire logic   pin,
  rptt_edge_if.src    edge_o
);

  if (STAGES < 2) begin : g_bad_stages
    $error("rptt_edge_sync needs at least two stages");
  end

  // ----------------------------------------
  // synchroniser chain and history
  // ----------------------------------------
  logic [STAGES-1:0] sync_q;
  logic              prev_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= '0;
      prev_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], pin};
      prev_q <= sync_q[STAGES-1];
    end
  end

  assign edge_o.level = sync_q[STAGES-1];
  assign edge_o.rise  = sync_q[STAGES-1] & ~prev_q;
  assign edge_o.fall  = ~sync_q[STAGES-1] & prev_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_single_rise: assert property (@(posedge clk_sys) disable iff (!rst_b)
    edge_o.rise |=> !edge_o.rise)
    else $error("rise pulse lasted more than one cycle");

  chk_rise_from_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
    edge_o.rise |-> ($past(pin, STAGES) && !$past(sync_q[STAGES-1])))
    else $error("rise seen without a low level before");

endmodule

// *** src/rptt_pkg.sv ***
// Purpose: shared types of the rate pin transition tracker
// Assumes: nothing
// Notes:   constants live in rptt_cfg.svh
package rptt_pkg;

  // ----------------------------------------
  // snapshot decision
  // ----------------------------------------
  typedef enum logic [1:0] {
    RPTT_SNAP_NONE  = 2'b00,
    RPTT_SNAP_KEEP  = 2'b01,
    RPTT_SNAP_CLEAR = 2'b10
  } rptt_snap_t;

  typedef logic [7:0] rptt_byte_t;

endpackage

// *** src/rptt_top.sv ***
// Purpose: tracks edges of the rate select pin and requests limited snapshots
// Assumes: register port and snapshot commands come from logic on clk_sys
// Notes:   read data appears one cycle after the read address
//
// Behaviour
// - A low to high pin change sets the rise seen flag, which stays 0 without one.
// - A high to low pin change sets the fall seen flag, which stays 0 without one.
// - Both seen flags clear only on a full snapshot command or its broadcast form.
// - With the clear enable at 0 a rising edge causes no clearing snapshot.
// - With the keep enable at 1 and the clear enable at 0 a rising edge causes a keeping snapshot, else none.
// - The enable bits change only when software writes them.
// - With the clear enable at 1 a rising edge causes a clearing snapshot.
// - When both enables are set only the clearing snapshot happens.
// - Only the clearing snapshot resets accumulators, and neither applies pending changes.
// - While the pin serves as alert output the whole register reads 0.
`timescale 1ns/1ps
`include "rptt_cfg.svh"

module rptt_top #(
  parameter int SYNC_STAGES = `RPTT_SYNC_STAGES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       rate_pin,
  input  wire logic       alert_mode,
  input  wire logic       full_snap_cmd,
  input  wire logic       full_snap_bcast_cmd,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            snap_clear,
  output logic            snap_keep,
  output logic            snap_apply_pending
);

  if (SYNC_STAGES < 2) begin : g_bad_stages
    $error("rptt_top needs at least two synchroniser stages");
  end

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  rptt_edge_if pin_edge ();

  rptt_edge_sync #(
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pin     (rate_pin),
    .edge_o  (pin_edge)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic                     rise_seen_flag_q;
  logic                     fall_seen_flag_q;
  logic [`RPTT_CTRL_MSB:0]  ctrl_q;
  rptt_pkg::rptt_byte_t     rdata_q;
  logic                     snap_clear_q;
  logic                     snap_keep_q;

  wire logic reg_hit     = (reg_addr == `RPTT_REG_ADDR);
  wire logic wr_hit      = reg_wr & reg_hit;
  wire logic full_snap   = full_snap_cmd | full_snap_bcast_cmd;
  wire logic rise_live   = pin_edge.rise & ~alert_mode;
  wire logic fall_live   = pin_edge.fall & ~alert_mode;
  wire logic en_clear    = ctrl_q[`RPTT_BIT_EN_CLEAR];
  wire logic en_keep     = ctrl_q[`RPTT_BIT_EN_KEEP];

  // set wins over clear on the seen flags
  wire logic rise_flag_d = rise_live | (rise_seen_flag_q & ~full_snap);
  wire logic fall_flag_d = fall_live | (fall_seen_flag_q & ~full_snap);

  // clearing snapshot wins over keeping snapshot
  rptt_pkg::rptt_snap_t snap_sel;
  assign snap_sel = !rise_live ? rptt_pkg::RPTT_SNAP_NONE :
                    en_clear   ? rptt_pkg::RPTT_SNAP_CLEAR :
                    en_keep    ? rptt_pkg::RPTT_SNAP_KEEP  :
                                 rptt_pkg::RPTT_SNAP_NONE;

  wire rptt_pkg::rptt_byte_t rd_word = {1'b0, rise_seen_flag_q, fall_seen_flag_q, ctrl_q};
  wire rptt_pkg::rptt_byte_t rd_next = (reg_hit && !alert_mode) ? rd_word : 8'h00;

  // ----------------------------------------
  // state
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rise_seen_flag_q <= 1'b0;
      fall_seen_flag_q <= 1'b0;
    end else begin
      rise_seen_flag_q <= rise_flag_d;
      fall_seen_flag_q <= fall_flag_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `RPTT_CTRL_RESET;
    end else if (wr_hit) begin
      ctrl_q <= reg_wdata[`RPTT_CTRL_MSB:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      snap_clear_q <= 1'b0;
      snap_keep_q  <= 1'b0;
      rdata_q      <= 8'h00;
    end else begin
      snap_clear_q <= (snap_sel == rptt_pkg::RPTT_SNAP_CLEAR);
      snap_keep_q  <= (snap_sel == rptt_pkg::RPTT_SNAP_KEEP);
      rdata_q      <= rd_next;
    end
  end

  assign snap_clear         = snap_clear_q;
  assign snap_keep          = snap_keep_q;
  assign snap_apply_pending = 1'b0;
  assign reg_rdata          = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_rise_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pin_edge.rise && !alert_mode) |=> rise_seen_flag_q)
    else $error("rise seen flag missed an edge");

  chk_fall_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pin_edge.fall && !alert_mode) |=> fall_seen_flag_q)
    else $error("fall seen flag missed an edge");

  chk_flags_rise_cause: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(rise_seen_flag_q) |-> $past(pin_edge.rise))
    else $error("rise seen flag set without an edge");

  chk_flags_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (full_snap && !pin_edge.rise && !pin_edge.fall) |=> (!rise_seen_flag_q && !fall_seen_flag_q))
    else $error("seen flags not cleared by full snapshot");

  chk_flags_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (fall_seen_flag_q && !full_snap) |=> fall_seen_flag_q [*1])
    else $error("fall seen flag dropped without full snapshot");

  chk_no_clear_snap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    snap_clear_q |-> ($past(en_clear) && $past(pin_edge.rise)))
    else $error("clearing snapshot without its enable");

  chk_keep_snap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pin_edge.rise && !alert_mode && en_keep && !en_clear) |=> snap_keep_q ##1 !snap_keep_q)
    else $error("keeping snapshot not a single pulse after rise");

  chk_enables_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !wr_hit |=> $stable(ctrl_q))
    else $error("enable bits changed without a write");

  chk_clear_snap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pin_edge.rise && !alert_mode && en_clear) |=> snap_clear_q)
    else $error("clearing snapshot missed a rise");

  chk_clear_wins: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pin_edge.rise && !alert_mode && en_clear && en_keep) |=> (snap_clear_q && !snap_keep_q))
    else $error("both snapshot kinds requested together");

  chk_no_pending: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (snap_clear_q || snap_keep_q) |-> !snap_apply_pending)
    else $error("limited snapshot applied pending changes");

  chk_alert_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    alert_mode |=> (reg_rdata == 8'h00))
    else $error("register not zero in alert mode");

endmodule
